/* logic/das_host_defs.vh */
// Behaviour
// (RULE1) Host may map the converter in memory space, accessed like static memory.
// (RULE2) In I/O space the I/O enable strobe qualifies accesses instead of memory strobes.
// (RULE3) Channel latch and start take effect on write strobe rise with select low.
// (RULE4) Write with A1 low latches channel number; byte select ignored.
// (RULE5) Write A1 high: byte select low starts 12-bit, high starts 8-bit.
// (RULE6) Read: byte select low gives 8 MSBs, high gives 4 LSBs and zeros.
// (RULE7) Without busy monitoring, host waits at least 30 us before reading result.
// (RULE8) Host may stall on the busy flag until conversion finishes.
// (RULE9) Host may take busy flag end as an interrupt request.
// (RULE10) Results are natural binary unipolar, offset binary bipolar.
// (RULE11) Falling read-or-convert starts conversion; busy rises; repeat start ignored.
// (RULE12) Data outputs float during conversion; enabled when read high after busy low.
// (RULE13) After 8-bit conversion low four bits read zero; low byte read optional.
// (RULE14) Host keeps channel number stable until next start is accepted.
`ifndef DAS_HOST_DEFS_VH
`define DAS_HOST_DEFS_VH
`define CLK_PERIOD_NS 20
`define CONV_WAIT_NS 30000
`define STROBE_NS 200
`define CMD_CHANNEL 2'h0
`define CMD_START12 2'h1
`define CMD_START8 2'h2
`define CMD_READ 2'h3
`define BUS_IDLE 1'h1
`endif

/* logic/strobe_timer.v */
`timescale 1ns/100ps
`include "das_host_defs.vh"
// Down counter: done pulses for one cycle as the count elapses, count cycles after the load
module strobe_timer #(
  parameter WIDTH = 16
) (
  input wire sys_clk,
  input wire rst,
  input wire clkEn,
  input wire load,
  input wire [WIDTH-1:0] count,
  output reg busy,
  output reg done
);
  reg [WIDTH-1:0] remain;

  // Count down while busy
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      remain <= {WIDTH{1'b0}};
      busy <= 1'b0;
      done <= 1'b0;
    end else if (clkEn) begin
      done <= 1'b0;
      if (load) begin
        remain <= count;
        busy <= 1'b1;
      end else if (busy) begin
        if (remain <= {{(WIDTH-1){1'b0}}, 1'b1}) begin
          busy <= 1'b0;
          done <= 1'b1;
        end else begin
          remain <= remain - {{(WIDTH-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule

/* logic/das_host_bus_interface.v */
`timescale 1ns/100ps
`include "das_host_defs.vh"
// Host side controller driving the acquisition unit pins as a bus master
module das_host_bus_interface #(
  parameter CONV_WAIT_CYCLES = (`CONV_WAIT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
  parameter STROBE_CYCLES = (`STROBE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
  parameter USE_BUSY = 1
) (
  input wire sys_clk,
  input wire rst,
  input wire clkEn,
  input wire cmdValid,
  input wire [1:0] cmdCode,
  input wire cmdByteSel,
  input wire [2:0] cmdChannel,
  output reg cmdReady,
  output reg [7:0] readData,
  output reg readValid,
  output reg convDone,
  output reg selectN,
  output reg writeN,
  output reg readN,
  output reg addrA1,
  output reg byteSelectLine,
  output reg [2:0] channelSelectLines,
  input wire [7:0] dataIn,
  input wire conversionBusyFlag
);
  // Sequencer states
  localparam S_IDLE = 3'h0;
  localparam S_STROBE = 3'h1;
  localparam S_RELEASE = 3'h2;
  localparam S_WAITCONV = 3'h3;
  // One timer serves both the strobe width and the conversion wait
  localparam TIMER_WIDTH = 16;

  reg [2:0] state;
  reg [2:0] next_state;
  reg [1:0] opCode;
  reg busySeen;
  reg timerLoad;
  reg [TIMER_WIDTH-1:0] timerCount;
  reg next_timerLoad;
  reg [TIMER_WIDTH-1:0] next_timerCount;
  wire timerDone;
  wire takeCmd;
  wire cmdIsRead;
  wire cmdIsChannel;
  wire cmdIsStart8;
  wire opIsRead;
  wire opIsStart;
  wire strobeEnd;
  wire busyEnd;
  wire convEnd;

  // Shared timer for strobe width and conversion wait
  strobe_timer #(
    .WIDTH(TIMER_WIDTH)
  ) i_strobe_timer (
    .sys_clk(sys_clk),
    .rst(rst),
    .clkEn(clkEn),
    .load(timerLoad),
    .count(timerCount),
    .busy(),
    .done(timerDone)
  );

  // Command decode at the user port
  assign takeCmd = cmdValid && cmdReady && (state == S_IDLE);
  assign cmdIsRead = (cmdCode == `CMD_READ);
  assign cmdIsChannel = (cmdCode == `CMD_CHANNEL);
  assign cmdIsStart8 = (cmdCode == `CMD_START8);

  // Decode of the command in progress
  assign opIsRead = (opCode == `CMD_READ);
  assign opIsStart = (opCode == `CMD_START12) || (opCode == `CMD_START8);

  // Events that end a strobe or a conversion wait
  assign strobeEnd = (state == S_STROBE) && timerDone;
  assign busyEnd = (USE_BUSY != 0) && busySeen && !conversionBusyFlag; // [RULE8]
  assign convEnd = (state == S_WAITCONV) && (timerDone || busyEnd); // [RULE7] [RULE8]

  // Next state of the sequencer
  always @* begin
    next_state = state;
    case (state)
      S_IDLE: begin
        if (takeCmd) begin
          next_state = S_STROBE;
        end
      end
      S_STROBE: begin
        if (strobeEnd) begin
          next_state = S_RELEASE;
        end
      end
      S_RELEASE: begin
        if (opIsStart) begin
          next_state = S_WAITCONV;
        end else begin
          next_state = S_IDLE;
        end
      end
      S_WAITCONV: begin
        if (convEnd) begin
          next_state = S_IDLE;
        end
      end
      default: begin
        next_state = S_IDLE;
      end
    endcase
  end

  // Timer requests: strobe width on a take, conversion wait after a start
  always @* begin
    next_timerLoad = 1'b0;
    next_timerCount = timerCount;
    if (takeCmd) begin
      next_timerLoad = 1'b1;
      next_timerCount = STROBE_CYCLES[TIMER_WIDTH-1:0];
    end else if ((state == S_RELEASE) && opIsStart) begin
      next_timerLoad = 1'b1;
      next_timerCount = CONV_WAIT_CYCLES[TIMER_WIDTH-1:0]; // Fixed wait [RULE7]
    end
  end

  // State register and timer request registers
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state <= S_IDLE;
      timerLoad <= 1'b0;
      timerCount <= {TIMER_WIDTH{1'b0}};
    end else if (clkEn) begin
      state <= next_state;
      timerLoad <= next_timerLoad;
      timerCount <= next_timerCount;
    end
  end

  // User handshake: ready in idle, dropped on the taking edge
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cmdReady <= 1'b0;
      opCode <= `CMD_CHANNEL;
    end else if (clkEn) begin
      if (takeCmd) begin
        cmdReady <= 1'b0;
        opCode <= cmdCode;
      end else if (state == S_IDLE) begin
        cmdReady <= 1'b1;
      end
    end
  end

  // Select and strobes; select stays low past the strobe rise
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      selectN <= `BUS_IDLE;
      writeN <= `BUS_IDLE;
      readN <= `BUS_IDLE;
    end else if (clkEn) begin
      if (takeCmd) begin
        selectN <= 1'b0; // Memory-like access [RULE1] [RULE2]
        if (cmdIsRead) begin
          readN <= 1'b0;
        end else begin
          writeN <= 1'b0;
        end
      end else if (strobeEnd) begin
        readN <= `BUS_IDLE;
        writeN <= `BUS_IDLE; // Action on rising strobe [RULE3]
      end else if (state == S_RELEASE) begin
        selectN <= `BUS_IDLE;
      end
    end
  end

  // Address lines, set up with the strobe fall
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      addrA1 <= 1'b0;
      byteSelectLine <= 1'b0;
      channelSelectLines <= 3'h0;
    end else if (clkEn && takeCmd) begin
      if (cmdIsRead) begin
        byteSelectLine <= cmdByteSel; // Picks the byte to return
      end else begin
        addrA1 <= !cmdIsChannel; // [RULE4] [RULE5]
        if (cmdIsChannel) begin
          byteSelectLine <= cmdByteSel; // Ignored by a channel latch [RULE4]
          channelSelectLines <= cmdChannel; // Held until next latch [RULE14]
        end else begin
          byteSelectLine <= cmdIsStart8; // [RULE5]
        end
      end
    end
  end

  // Read data taken while the read strobe still stands
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      readData <= 8'h00;
      readValid <= 1'b0;
    end else if (clkEn) begin
      readValid <= 1'b0;
      if (strobeEnd && opIsRead) begin
        readData <= dataIn; // MSBs or LSBs plus zeros [RULE6] [RULE10] [RULE13]
        readValid <= 1'b1;
      end
    end
  end

  // Busy watch: a rise seen after the start, then a fall, ends the wait [RULE8]
  // A device whose flag never rises is still released by the fixed wait
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      busySeen <= 1'b0;
      convDone <= 1'b0;
    end else if (clkEn) begin
      convDone <= convEnd; // End of conversion event [RULE9]
      if (takeCmd || convEnd) begin
        busySeen <= 1'b0;
      end else if (opIsStart && (state == S_RELEASE || state == S_WAITCONV) &&
                   conversionBusyFlag) begin
        busySeen <= 1'b1;
      end
    end
  end
endmodule

/* verification/das_host_props.sv */
`timescale 1ns/100ps
module das_host_props (
  input logic sys_clk,
  input logic rst,
  input logic cmdReady,
  input logic convDone,
  input logic selectN,
  input logic writeN,
  input logic readN,
  input logic addrA1,
  input logic [2:0] channelSelectLines
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  AST_WSEL: assert property (!writeN |-> !selectN) else $error("write without select");
  AST_RSEL: assert property (!readN |-> !selectN) else $error("read without select");
  AST_ONE: assert property (writeN || readN) else $error("both strobes low");
  AST_RISE: assert property ($rose(writeN) |-> !selectN) else $error("select gone");
  AST_A1: assert property (!writeN |=> writeN || $stable(addrA1)) else $error("A1 moved");
  AST_CH: assert property (!writeN |=> $stable(channelSelectLines)) else $error("chan moved");
  AST_WAIT: assert property ($rose(writeN) && addrA1 |=> (readN && !convDone) [*8])
    else $error("early read");
  AST_RDY: assert property (!selectN |-> !cmdReady) else $error("ready in cycle");
endmodule
bind das_host_bus_interface das_host_props i_das_host_props (.*);

/* verification/das_dev_model.sv */
`timescale 1ns/100ps
module das_dev_model #(parameter BUSY_NS = 200) (
  input logic selectN,
  input logic writeN,
  input logic readN,
  input logic addrA1,
  input logic byteSelectLine,
  input logic [2:0] channelSelectLines,
  output logic [7:0] dataIn,
  output logic conversionBusyFlag = 1'b0
);
  logic [11:0] res = 12'h000;
  logic [7:0] val;
  // Start a conversion, repeat starts while busy are dropped
  always @(posedge writeN) if (!selectN && addrA1 && !conversionBusyFlag) begin
    conversionBusyFlag <= 1'b1;
    res <= {channelSelectLines, 9'h1A5} & (byteSelectLine ? 12'hFF0 : 12'hFFF);
    #(BUSY_NS) conversionBusyFlag <= 1'b0;
  end
  // Byte mux; a released bus shows a changed pattern
  assign val = byteSelectLine ? {res[3:0], 4'h0} : res[11:4];
  assign dataIn = (!selectN && !readN && !conversionBusyFlag) ? val : ~val;
endmodule

/* verification/das_host_bus_interface_tb.sv */
`timescale 1ns/100ps
module das_host_bus_interface_tb;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic cmdValid = 1'b0;
  logic cmdByteSel = 1'b0;
  logic [1:0] cmdCode = 2'h0;
  logic [2:0] cmdChannel = 3'h0;
  wire cmdReady, readValid, convDone, selectN, writeN, readN, addrA1;
  wire byteSelectLine, conversionBusyFlag;
  wire [7:0] readData, dataIn;
  wire [2:0] channelSelectLines;
  int bad_count = 0;
  int cmp_count = 0;
  // Clock
  always #10 sys_clk = ~sys_clk;
  das_host_bus_interface #(.CONV_WAIT_CYCLES(20), .STROBE_CYCLES(2)) i_das_host_bus_interface (
    .clkEn(1'b1), .*);
  das_dev_model i_das_dev_model (.*);
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Issue one command and wait for its completion
  task automatic op(input logic [1:0] c, input logic b, input logic [2:0] ch);
    int n;
    n = 0;
    @(negedge sys_clk);
    cmdCode = c;
    cmdByteSel = b;
    cmdChannel = ch;
    cmdValid = 1'b1;
    while (cmdReady !== 1'b1 && n < 60) begin
      @(negedge sys_clk);
      n++;
    end
    @(negedge sys_clk);
    cmdValid = 1'b0;
    while ((c == 2'h0 ? cmdReady : c == 2'h3 ? readValid : convDone) !== 1'b1 && n < 60) begin
      @(negedge sys_clk);
      n++;
    end
    if (n >= 60) begin
      bad_count++;
      $display("ERROR %0t timeout got %h exp below %h", $time, n, 60);
    end
  endtask
  task summarize;
    if (bad_count == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Watchdog
  initial begin
    #100000;
    bad_count++;
    summarize;
  end
  // Tests
  initial begin
    repeat (8) @(negedge sys_clk);
    rst = 1'b0;
    op(2'h0, 1'b1, 3'h5);
    chk({5'h00, channelSelectLines}, 8'h05);
    op(2'h1, 1'b0, 3'h5);
    op(2'h3, 1'b0, 3'h5);
    chk(readData, 8'hBA);
    op(2'h3, 1'b1, 3'h5);
    chk(readData, 8'h50);
    op(2'h0, 1'b0, 3'h3);
    op(2'h2, 1'b0, 3'h3);
    op(2'h3, 1'b1, 3'h3);
    chk(readData, 8'h00);
    op(2'h3, 1'b0, 3'h3);
    chk(readData, 8'h7A);
    summarize;
  end
endmodule
